// ===== hw/sar_adc_control.sv
// Successive-approximation converter control with AXI4-Lite registers
//
// Our own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module sar_adc_control (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic [31:0] s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic [1:0]       s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  input  wire logic [31:0] s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic [31:0]      s_axi_rdata_o,
  output logic [1:0]       s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i,
  input  wire logic        comp_above_i,
  input  wire logic        ext_irq_three_i,
  output logic [2:0]       channel_sel_o,
  output logic [7:0]       trial_code_o,
  output logic             ladder_on_o,
  output logic             irq_o
);
  logic [2:0]  channel_r;
  logic        done_r;
  logic        ladder_r;
  logic [7:0]  result_r;
  logic [7:0]  polarity_r;
  logic [1:0]  irq_status_r;
  logic [1:0]  irq_enable_r;
  sar_adc_pkg::conv_state_t state_r;
  logic [2:0]  bit_r;
  logic [5:0]  wait_r;
  logic        aw_held_r;
  logic        w_held_r;
  sar_adc_pkg::reg_access_t wr_r;
  logic [3:0]  wstrb_r;
  logic        do_write;
  logic        start_conv;
  logic        conv_finish;
  logic        cmp_q1_r, cmp_q2_r, cmp_q3_r, cmp_r;
  logic        pin_q1_r, pin_q2_r, pin_q3_r, pin_r, pin_prev_r;
  logic        shared_src;
  logic [1:0]  irq_set;
  logic        wr_hit_ctrl;
  logic        wr_hit_en;
  logic        wr_hit_clr;
  logic        wr_hit_pol;

  // Write channel capture: address and data taken in either order
  assign s_axi_awready_o = !aw_held_r && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_held_r && !s_axi_bvalid_o;
  assign do_write        = aw_held_r && w_held_r && !s_axi_bvalid_o;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      wr_r      <= '0;
      wstrb_r   <= 4'h0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held_r    <= 1'b1;
        wr_r.addr    <= s_axi_awaddr_i[7:0];
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held_r  <= 1'b1;
        wr_r.data <= s_axi_wdata_i;
        wstrb_r   <= s_axi_wstrb_i;
      end
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
      end
    end
  end

  assign wr_hit_ctrl = do_write && wstrb_r[0] && wr_r.addr == sar_adc_pkg::ADDR_CONTROL;
  assign wr_hit_en   = do_write && wstrb_r[0] && wr_r.addr == sar_adc_pkg::ADDR_IRQ_ENABLE;
  assign wr_hit_clr  = do_write && wstrb_r[0] && wr_r.addr == sar_adc_pkg::ADDR_IRQ_CLEAR;
  assign wr_hit_pol  = do_write && wstrb_r[0] && wr_r.addr == sar_adc_pkg::ADDR_POLARITY;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= sar_adc_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= (wr_r.addr == sar_adc_pkg::ADDR_CONTROL ||
                         wr_r.addr == sar_adc_pkg::ADDR_IRQ_ENABLE ||
                         wr_r.addr == sar_adc_pkg::ADDR_IRQ_CLEAR ||
                         wr_r.addr == sar_adc_pkg::ADDR_POLARITY) ?
                        sar_adc_pkg::RESP_OKAY : sar_adc_pkg::RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // Control register: channel, ladder, completion flag
  assign start_conv = wr_hit_ctrl && !wr_r.data[sar_adc_pkg::DONE_BIT]
                      && state_r == sar_adc_pkg::CONV_IDLE;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      channel_r <= sar_adc_pkg::CONTROL_RESET[2:0];
      ladder_r  <= sar_adc_pkg::CONTROL_RESET[sar_adc_pkg::LADDER_BIT];
    end else if (wr_hit_ctrl) begin
      channel_r <= wr_r.data[sar_adc_pkg::CH_LSB +: sar_adc_pkg::CH_W];
      ladder_r  <= wr_r.data[sar_adc_pkg::LADDER_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      done_r <= sar_adc_pkg::CONTROL_RESET[sar_adc_pkg::DONE_BIT];
    end else if (conv_finish) begin
      done_r <= 1'b1;
    end else if (start_conv) begin
      done_r <= 1'b0;
    end
  end

  // Comparator and pin inputs come from outside the clock domain
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {cmp_q1_r, cmp_q2_r, cmp_q3_r, cmp_r} <= 4'h0;
      {pin_q1_r, pin_q2_r, pin_q3_r, pin_r, pin_prev_r} <= 5'h00;
    end else begin
      cmp_q1_r   <= comp_above_i;
      cmp_q2_r   <= cmp_q1_r;
      cmp_q3_r   <= cmp_q2_r;
      pin_q1_r   <= ext_irq_three_i;
      pin_q2_r   <= pin_q1_r;
      pin_q3_r   <= pin_q2_r;
      pin_prev_r <= pin_r;
      if (cmp_q2_r == cmp_q3_r) begin
        cmp_r <= cmp_q3_r;
      end
      if (pin_q2_r == pin_q3_r) begin
        pin_r <= pin_q3_r;
      end
    end
  end

  // Successive-approximation sequencer
  assign conv_finish = state_r == sar_adc_pkg::CONV_DONE;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r  <= sar_adc_pkg::CONV_IDLE;
      result_r <= sar_adc_pkg::RESULT_RESET;
      bit_r    <= 3'h0;
      wait_r   <= 6'h00;
    end else begin
      unique case (state_r)
        sar_adc_pkg::CONV_IDLE: begin
          if (start_conv) begin
            result_r <= sar_adc_pkg::RESULT_RESET;
            state_r  <= sar_adc_pkg::CONV_CLEAR;
          end
        end
        sar_adc_pkg::CONV_CLEAR: begin
          bit_r              <= sar_adc_pkg::BIT_MSB;
          result_r[sar_adc_pkg::BIT_MSB] <= 1'b1;
          wait_r             <= 6'h00;
          state_r            <= sar_adc_pkg::CONV_TRIAL;
        end
        sar_adc_pkg::CONV_TRIAL: begin
          if (wait_r == sar_adc_pkg::CYC_SETTLE) begin
            result_r[bit_r] <= cmp_r;
            wait_r          <= 6'h00;
            if (bit_r == 3'h0) begin
              state_r <= sar_adc_pkg::CONV_DONE;
            end else begin
              bit_r                 <= bit_r - 3'h1;
              result_r[bit_r - 3'h1] <= 1'b1;
            end
          end else begin
            wait_r <= wait_r + 6'h01;
          end
        end
        sar_adc_pkg::CONV_DONE: begin
          state_r <= sar_adc_pkg::CONV_IDLE;
        end
      endcase
    end
  end

  // Trial code drives the ladder tap; code n sits at n minus half a step
  assign trial_code_o  = result_r;
  assign channel_sel_o = channel_r;
  assign ladder_on_o   = ladder_r;

  // Shared request source, status, enable and clear
  assign shared_src = polarity_r[sar_adc_pkg::POL_ADC_BIT] ? conv_finish
                      : (pin_r && !pin_prev_r);
  assign irq_set    = {1'b0, shared_src};

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      polarity_r   <= sar_adc_pkg::POLARITY_RESET;
      irq_enable_r <= 2'h0;
    end else begin
      if (wr_hit_pol) begin
        polarity_r <= wr_r.data[7:0];
      end
      if (wr_hit_en) begin
        irq_enable_r <= wr_r.data[1:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_status_r <= 2'h0;
    end else begin
      // Start does not touch the request; a set wins over a clear
      irq_status_r <= (irq_status_r & ~(wr_hit_clr ? wr_r.data[1:0] : 2'h0))
                      | irq_set;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_status_r & irq_enable_r);
    end
  end

  // Read channel
  assign s_axi_arready_o = !s_axi_rvalid_o;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= sar_adc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o  <= sar_adc_pkg::RESP_OKAY;
      s_axi_rdata_o  <= 32'h0000_0000;
      unique case (s_axi_araddr_i[7:0])
        sar_adc_pkg::ADDR_RESULT:     s_axi_rdata_o[7:0] <= result_r;
        sar_adc_pkg::ADDR_CONTROL:    s_axi_rdata_o[4:0] <= {ladder_r, done_r, channel_r};
        sar_adc_pkg::ADDR_IRQ_STATUS: s_axi_rdata_o[1:0] <= irq_status_r;
        sar_adc_pkg::ADDR_IRQ_ENABLE: s_axi_rdata_o[1:0] <= irq_enable_r;
        sar_adc_pkg::ADDR_POLARITY:   s_axi_rdata_o[7:0] <= polarity_r;
        default:                      s_axi_rresp_o      <= sar_adc_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // Assertions
  logic [6:0] conv_cnt_r;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conv_cnt_r <= 7'h00;
    end else if (start_conv) begin
      conv_cnt_r <= 7'h01;
    end else if (state_r != sar_adc_pkg::CONV_IDLE) begin
      conv_cnt_r <= conv_cnt_r + 7'h01;
    end
  end

  property p_start_clears_done;
    @(posedge clk_i) disable iff (!nrst_i) start_conv |=> !done_r;
  endproperty
  a_start_clears_done: assert property (p_start_clears_done) else $error("done not cleared");

  property p_done_low_busy;
    @(posedge clk_i) disable iff (!nrst_i)
      (state_r != sar_adc_pkg::CONV_IDLE && !conv_finish) |=> !done_r || conv_finish;
  endproperty
  a_done_low_busy: assert property (p_done_low_busy) else $error("done high while busy");

  property p_finish_sets_done;
    @(posedge clk_i) disable iff (!nrst_i) conv_finish |=> done_r;
  endproperty
  a_finish_sets_done: assert property (p_finish_sets_done) else $error("done not set");

  property p_clear_result;
    @(posedge clk_i) disable iff (!nrst_i) start_conv |=> result_r == 8'h00;
  endproperty
  a_clear_result: assert property (p_clear_result) else $error("result not cleared");

  property p_msb_trial;
    @(posedge clk_i) disable iff (!nrst_i) start_conv |=> ##1 result_r == 8'h80;
  endproperty
  a_msb_trial: assert property (p_msb_trial) else $error("msb trial missing");

  property p_within_50;
    @(posedge clk_i) disable iff (!nrst_i)
      state_r != sar_adc_pkg::CONV_IDLE |-> conv_cnt_r <= 7'(sar_adc_pkg::MAX_CONV_CYCLES);
  endproperty
  a_within_50: assert property (p_within_50) else $error("conversion too long");

  property p_finish_by_50;
    @(posedge clk_i) disable iff (!nrst_i) start_conv |-> ##[1:50] conv_finish;
  endproperty
  a_finish_by_50: assert property (p_finish_by_50) else $error("no finish in 50");

  property p_one_no_start;
    @(posedge clk_i) disable iff (!nrst_i)
      (wr_hit_ctrl && wr_r.data[sar_adc_pkg::DONE_BIT] && state_r == sar_adc_pkg::CONV_IDLE)
      |=> state_r == sar_adc_pkg::CONV_IDLE;
  endproperty
  a_one_no_start: assert property (p_one_no_start) else $error("one started conversion");

  property p_irq_route;
    @(posedge clk_i) disable iff (!nrst_i)
      (conv_finish && polarity_r[sar_adc_pkg::POL_ADC_BIT]) |=> irq_status_r[0];
  endproperty
  a_irq_route: assert property (p_irq_route) else $error("request not set");

  property p_result_hold;
    @(posedge clk_i) disable iff (!nrst_i)
      (state_r == sar_adc_pkg::CONV_IDLE && !start_conv) |=> $stable(result_r);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result changed idle");

  c_conv: cover property (@(posedge clk_i) disable iff (!nrst_i) start_conv ##[1:50] conv_finish);
  c_irq: cover property (@(posedge clk_i) disable iff (!nrst_i) irq_o);
  c_full: cover property (@(posedge clk_i) disable iff (!nrst_i) conv_finish && result_r == 8'hFF);
endmodule : sar_adc_control

// ===== hw/sar_adc_pkg.sv
// Package with register map, field positions and timing constants for the converter control
package sar_adc_pkg;
  localparam logic [7:0]  ADDR_RESULT      = 8'h00;
  localparam logic [7:0]  ADDR_CONTROL     = 8'h04;
  localparam logic [7:0]  ADDR_IRQ_STATUS  = 8'h08;
  localparam logic [7:0]  ADDR_IRQ_ENABLE  = 8'h0C;
  localparam logic [7:0]  ADDR_IRQ_CLEAR   = 8'h10;
  localparam logic [7:0]  ADDR_POLARITY    = 8'h14;
  localparam int          CH_LSB           = 0;
  localparam int          CH_W             = 3;
  localparam int          DONE_BIT         = 3;
  localparam int          LADDER_BIT       = 4;
  localparam int          POL_ADC_BIT      = 7;
  localparam int          RES_W            = 8;
  localparam logic [7:0]  CONTROL_RESET    = 8'h08;
  localparam logic [7:0]  RESULT_RESET     = 8'h00;
  localparam logic [7:0]  POLARITY_RESET   = 8'h00;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
  localparam int          MAX_CONV_CYCLES  = 50;
  localparam int          CONV_WAIT_CYCLES = 4;
  localparam logic [5:0]  CYC_SETTLE       = 6'h04;
  localparam logic [2:0]  BIT_MSB          = 3'h7;
  localparam logic [1:0]  IRQ_CONV         = 2'h0;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] data;
  } reg_access_t;

  typedef enum logic [1:0] {
    CONV_IDLE  = 2'b00,
    CONV_CLEAR = 2'b01,
    CONV_TRIAL = 2'b10,
    CONV_DONE  = 2'b11
  } conv_state_t;
endpackage : sar_adc_pkg

// ===== verification/sar_adc_analog_model.sv
// Behavioural comparator, resistor ladder and input multiplexer
`timescale 1ns/1ps
module sar_adc_analog_model (
  input  wire logic            clk_i,
  input  wire logic [7:0][8:0] level_i,
  input  wire logic [2:0]      channel_sel_i,
  input  wire logic [7:0]      trial_code_i,
  input  wire logic            ladder_on_i,
  input  wire logic            slow_i,
  output logic                 comp_above_o
);
  logic [9:0] vref2;
  logic       prompt;
  logic       late_r;
  logic       junk_r = 1'b0;
  // Levels in half steps: code zero gives zero, code n gives 2n-1
  assign vref2 = (trial_code_i == 8'h00) ? 10'h000 : {1'b0, trial_code_i, 1'b0} - 10'h001;
  assign prompt = vref2 < {1'b0, level_i[channel_sel_i]};
  // Slow comparator settles half a cycle late, still ahead of the next sampling edge
  always @(negedge clk_i) begin
    late_r <= prompt;
    junk_r <= ~junk_r;
  end
  // Without the ladder the output means nothing
  assign comp_above_o = !ladder_on_i ? junk_r : (slow_i ? late_r : prompt);
endmodule : sar_adc_analog_model

// ===== verification/sar_adc_control_tb.sv
// Self-checking bench for the converter control
`timescale 1ns/1ps
module sar_adc_control_tb;
  localparam logic [7:0] RES = sar_adc_pkg::ADDR_RESULT;
  localparam logic [7:0] CTL = sar_adc_pkg::ADDR_CONTROL;
  localparam logic [7:0] STA = sar_adc_pkg::ADDR_IRQ_STATUS;
  localparam logic [7:0] ENA = sar_adc_pkg::ADDR_IRQ_ENABLE;
  localparam logic [7:0] CLR = sar_adc_pkg::ADDR_IRQ_CLEAR;
  localparam logic [7:0] POL = sar_adc_pkg::ADDR_POLARITY;
  localparam logic [1:0] OK  = sar_adc_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = sar_adc_pkg::RESP_SLVERR;
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} note_t;
  logic clk_i = 1'b0, nrst_i = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, comp, ladder, irq, slow = 1'b0, ext = 1'b0;
  logic [1:0] bresp, rresp;
  logic [2:0] chan;
  logic [7:0] trial, expv;
  logic [7:0][8:0] level = '0;
  logic [31:0] seed = 32'h45;
  logic watch = 1'b0, saw_clear, saw_msb;
  note_t rq[$], wq[$];
  int compares = 0, miscompares = 0, cyc, ch;
  always #5 clk_i = ~clk_i;
  sar_adc_control i_sar_adc_control (.clk_i(clk_i), .nrst_i(nrst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .comp_above_i(comp),
    .ext_irq_three_i(ext), .channel_sel_o(chan), .trial_code_o(trial),
    .ladder_on_o(ladder), .irq_o(irq));
  sar_adc_analog_model i_sar_adc_analog_model (.clk_i(clk_i), .level_i(level),
    .channel_sel_i(chan), .trial_code_i(trial), .ladder_on_i(ladder), .slow_i(slow),
    .comp_above_o(comp));
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xorshift
  task automatic results();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  task automatic bad(input string s);
    miscompares++;
    $display("MISMATCH t=%0t %s", $time, s);
  endtask : bad
  task automatic timeout();
    bad("wait ran out");
    results();
  endtask : timeout
  task automatic cmp_read(input note_t n);
    compares++;
    if (((rdata & n.m) !== (n.d & n.m)) || (rresp !== n.r)) bad("read data or response");
  endtask : cmp_read
  task automatic cmp_resp(input note_t n);
    compares++;
    if (((bresp ^ n.r) & n.m[1:0]) !== 2'h0) bad("write response");
  endtask : cmp_resp
  task automatic cmp_port(input logic [31:0] got, input logic [31:0] want);
    compares++;
    if (got !== want) bad("port value");
  endtask : cmp_port
  // Results are checked on the falling edge, half a cycle before their handshake edge
  always @(negedge clk_i) begin
    if (bvalid === 1'b1 && bready && wq.size() > 0) cmp_resp(wq.pop_front());
    if (rvalid === 1'b1 && rready && rq.size() > 0) cmp_read(rq.pop_front());
    if (watch && trial === 8'h00) saw_clear = 1'b1;
    if (watch && trial === 8'h80 && saw_clear) saw_msb = 1'b1;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = OK,
                    input logic [1:0] m = 2'h3);
    logic aw_ok, w_ok, b_ok;
    int k;
    wq.push_back('{32'h0, {30'h0, m}, r});
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_ok = 1'b0;
    for (k = 0; k < 100 && !b_ok; k++) begin
      @(negedge clk_i);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid && bready;
      @(posedge clk_i);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      if (b_ok) bready <= 1'b0;
    end
    // One idle edge so the next call never re-raises bready in the same step
    @(posedge clk_i);
    if (!b_ok) timeout();
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m = 32'hFF,
                    input logic [1:0] r = OK);
    logic ar_ok, r_ok;
    int k;
    rq.push_back('{d, m, r});
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_ok = 1'b0;
    for (k = 0; k < 100 && !r_ok; k++) begin
      @(negedge clk_i);
      ar_ok = arvalid && arready;
      r_ok = rvalid && rready;
      @(posedge clk_i);
      if (ar_ok) arvalid <= 1'b0;
      if (r_ok) rready <= 1'b0;
    end
    // One idle edge so the next call never re-raises rready in the same step
    @(posedge clk_i);
    if (!r_ok) timeout();
  endtask : rd
  task automatic wait_irq(input logic v, output int c);
    logic hit;
    hit = 1'b0;
    for (c = 0; c < 200 && !hit; c++) begin
      @(negedge clk_i);
      hit = (irq === v);
    end
    @(posedge clk_i);
    if (!hit) timeout();
  endtask : wait_irq
  initial begin
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(RES, sar_adc_pkg::RESULT_RESET);
    rd(CTL, sar_adc_pkg::CONTROL_RESET);
    rd(POL, sar_adc_pkg::POLARITY_RESET);
    rd(STA, 32'h0, 32'h1);
    rd(8'h18, 32'h0, 32'h0, ERR);
    wr(8'h18, 32'h0, ERR);
    wr(RES, 32'hFF, ERR);
    rd(RES, 32'h0);
    $display("test reset_map done");
    wr(POL, 32'h80);
    wr(ENA, 32'h1);
    wr(CTL, 32'h18);
    repeat (60) @(posedge clk_i);
    rd(CTL, 32'h18);
    rd(STA, 32'h0, 32'h1);
    $display("test idle_write done");
    for (ch = 0; ch < 8; ch++) begin
      seed = xorshift(seed);
      expv = (ch == 0) ? 8'h00 : (ch == 7) ? 8'hFF : seed[7:0];
      level[ch] <= {expv, 1'b0};
      slow <= seed[8];
      ext <= seed[9];
      wr(CLR, 32'h1);
      wr(CTL, 32'h18 | ch);
      cmp_port(chan, ch);
      cmp_port(ladder, 1);
      saw_clear = 1'b0;
      saw_msb = 1'b0;
      watch = 1'b1;
      wr(CTL, 32'h10 | ch);
      rd(CTL, 32'h10 | ch, 32'h1F);
      wr(CTL, 32'h18 | ch);
      wait_irq(1'b1, cyc);
      watch = 1'b0;
      cmp_port(cyc <= sar_adc_pkg::MAX_CONV_CYCLES, 1);
      cmp_port({saw_clear, saw_msb}, 3);
      rd(CTL, 32'h18 | ch);
      rd(STA, 32'h1, 32'h1);
      rd(RES, expv);
      wr(CTL, 32'h08 | ch);
      cmp_port(ladder, 0);
      rd(RES, expv);
    end
    $display("test conversions done");
    wr(CTL, 32'h1B);
    wr(CTL, 32'h13);
    rd(STA, 32'h1, 32'h1);
    repeat (60) @(posedge clk_i);
    rd(CTL, 32'h1B);
    $display("test start_keeps_request done");
    ext <= 1'b0;
    repeat (10) @(posedge clk_i);
    wr(POL, 32'h0);
    wr(ENA, 32'h0);
    wr(CLR, 32'h1);
    wr(CTL, 32'h13);
    repeat (60) @(posedge clk_i);
    rd(STA, 32'h0, 32'h1);
    ext <= 1'b1;
    repeat (10) @(posedge clk_i);
    rd(STA, 32'h1, 32'h1);
    cmp_port(irq, 0);
    wr(ENA, 32'h1);
    wait_irq(1'b1, cyc);
    wr(CLR, 32'h1);
    wait_irq(1'b0, cyc);
    rd(STA, 32'h0, 32'h1);
    $display("test pin_route done");
    results();
  end
endmodule : sar_adc_control_tb
